// [design/ils_pkg.sv]
package ils_pkg;

    // serial target address
    localparam logic [6:0] TARGET_ADDR     = 7'h20;

    // register offsets
    localparam logic [7:0] OFS_CH_SETUP    = 8'h02;
    localparam logic [7:0] OFS_CH_EN_2_9   = 8'h03;
    localparam logic [7:0] OFS_SHARED_CODE = 8'h04;
    localparam logic [7:0] OFS_CH1_CODE    = 8'h05;
    localparam logic [7:0] OFS_CH9_CODE    = 8'h0D;
    localparam logic [7:0] OFS_ERR_STAT_A  = 8'h0E;
    localparam logic [7:0] OFS_ERR_STAT_B  = 8'h0F;
    localparam logic [7:0] OFS_ERR_CLEAR   = 8'h10;
    localparam logic [7:0] OFS_CONV_SETUP  = 8'h11;
    localparam logic [7:0] OFS_OP_STATUS   = 8'h13;

    // channel setup fields
    localparam int SETUP_GLOBAL_BIT   = 7;
    localparam int SETUP_EXCL_LSB     = 2;
    localparam int SETUP_GLOBAL_ON    = 1;
    localparam int SETUP_CH1_ON       = 0;

    // converter setup fields
    localparam int CONV_ON_A_BIT      = 3;
    localparam int CONV_ON_B_BIT      = 2;
    localparam int CONV_SW_SEL_BIT    = 1;
    localparam int CONV_SKIP_BIT      = 0;

    // status fields
    localparam int STAT_A_OPEN_BIT    = 7;
    localparam int STAT_A_SHORT_BIT   = 6;
    localparam int STAT_A_CH_COUNT    = 6;
    localparam int STAT_B_SUPPLY_BIT  = 7;
    localparam int OP_OVP_BIT         = 2;
    localparam int OP_THERMAL_BIT     = 1;
    localparam int OP_ACTIVE_BIT      = 0;
    localparam int CLEAR_BIT          = 0;

    // reset values
    localparam logic [7:0] REG_RESET  = 8'h00;

endpackage

// [design/ils_top.sv]
`timescale 1ns/10ps
module ils_top
    import ils_pkg::*;
#(
    parameter int NUM_CH = 9,
    parameter int CODE_W = 6
)(
    // clock and power-on reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // serial register port
    input  wire logic                          scl_in,
    input  wire logic                          sda_in,
    output logic                               sda_out,
    output logic                               sda_oe,
    // control pins
    input  wire logic                          hw_enable,
    input  wire logic                          mode_pin,
    input  wire logic                          err_clear_pin,
    // analog sense
    input  wire logic [NUM_CH-1:0]             open_detect,
    input  wire logic [NUM_CH-1:0]             short_detect,
    input  wire logic                          supply_fault,
    input  wire logic                          thermal_fault,
    input  wire logic                          vout_ovp_fault,
    // converter and sink control
    output logic                               active,
    output logic                               conv_enable,
    output logic                               conv_auto_skip,
    output logic [NUM_CH-1:0]                  chan_on,
    output logic [NUM_CH-1:0][CODE_W-1:0]      chan_code,
    // open-drain alarm
    output logic                               alarm_out,
    output logic                               alarm_oe
);

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000,
        ST_ADDR  = 4'b0001,
        ST_AACK  = 4'b0010,
        ST_PTR   = 4'b0011,
        ST_PACK  = 4'b0100,
        ST_WR    = 4'b0101,
        ST_WACK  = 4'b0110,
        ST_RD    = 4'b0111,
        ST_RACK  = 4'b1000
    } ils_state_type;

    logic                      rst_s1_q;
    logic                      rst_n_q;
    ils_state_type             st_q;
    logic [3:0]                cnt_q;
    logic [7:0]                shift_q;
    logic [7:0]                ptr_q;
    logic                      rw_q;
    logic                      ack_q;
    logic                      scl_q;
    logic                      sda_q;
    logic                      wr_stb_q;
    logic [7:0]                wr_data_q;
    logic [7:0]                wr_ptr_q;
    logic [7:0]                setup_q;
    logic [7:0]                en29_q;
    logic [7:0]                shared_q;
    logic [7:0]                conv_q;
    logic [7:0]                code_q [NUM_CH];
    logic [NUM_CH-1:0]         fault_q;
    logic                      open_flag_q;
    logic                      short_flag_q;
    logic                      clr_pin_q;
    logic                      clr_d;
    logic                      start_c;
    logic                      stop_c;
    logic                      rise_c;
    logic                      fall_c;
    logic [NUM_CH-1:0]         req_c;
    logic [NUM_CH-1:0]         cond_c;
    logic [7:0]                rd_c;
    logic [3:0]                excl_c;

    // read mux over the register map
    function automatic logic [7:0] rd_mux(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == OFS_CH_SETUP)
            v = setup_q;
        else if (a == OFS_CH_EN_2_9)
            v = en29_q;
        else if (a == OFS_SHARED_CODE)
            v = shared_q;
        else if (a >= OFS_CH1_CODE && a <= OFS_CH9_CODE)
            v = code_q[4'(a - OFS_CH1_CODE)];
        else if (a == OFS_ERR_STAT_A)
        begin
            v[STAT_A_CH_COUNT-1:0] = fault_q[STAT_A_CH_COUNT-1:0];
            v[STAT_A_SHORT_BIT]    = short_flag_q;
            v[STAT_A_OPEN_BIT]     = open_flag_q;
        end
        else if (a == OFS_ERR_STAT_B)
        begin
            v[NUM_CH-STAT_A_CH_COUNT-1:0] = fault_q[NUM_CH-1:STAT_A_CH_COUNT];
            v[STAT_B_SUPPLY_BIT]          = supply_fault;
        end
        else if (a == OFS_CONV_SETUP)
            v = conv_q;
        else if (a == OFS_OP_STATUS)
        begin
            v[OP_OVP_BIT]     = vout_ovp_fault;
            v[OP_THERMAL_BIT] = thermal_fault;
            v[OP_ACTIVE_BIT]  = active;
        end
        return v;
    endfunction

    // reset release
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            {rst_n_q, rst_s1_q} <= 2'h0;
        else
            {rst_n_q, rst_s1_q} <= {rst_s1_q, 1'b1};
    end

    // bus line history
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            {scl_q, sda_q, clr_pin_q} <= 3'h6;
        else
            {scl_q, sda_q, clr_pin_q} <= {scl_in, sda_in, err_clear_pin};
    end

    assign start_c = scl_in && scl_q && sda_q && !sda_in;
    assign stop_c  = scl_in && scl_q && !sda_q && sda_in;
    assign rise_c  = scl_in && !scl_q;
    assign fall_c  = !scl_in && scl_q;
    always_comb
        rd_c = rd_mux(ptr_q);

    // serial target engine
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            st_q     <= ST_IDLE;
            cnt_q    <= 4'h0;
            shift_q  <= 8'h00;
            ptr_q    <= 8'h00;
            {rw_q, ack_q, sda_oe, sda_out, wr_stb_q} <= 5'h00;
            {wr_data_q, wr_ptr_q}                     <= 16'h0000;
        end
        else
        begin
            sda_out  <= 1'b0;
            wr_stb_q <= 1'b0;
            if (start_c)
            begin
                st_q   <= ST_ADDR;
                cnt_q  <= 4'h0;
                sda_oe <= 1'b0;
            end
            else if (stop_c)
            begin
                st_q   <= ST_IDLE;
                sda_oe <= 1'b0;
            end
            else if (rise_c)
            begin
                if (st_q == ST_ADDR || st_q == ST_PTR || st_q == ST_WR)
                begin
                    shift_q <= {shift_q[6:0], sda_in};
                    cnt_q   <= cnt_q + 4'h1;
                end
                else if (st_q == ST_RACK)
                begin
                    ack_q <= !sda_in;
                    if (!sda_in)
                        ptr_q <= ptr_q + 8'h01;
                end
            end
            else if (fall_c)
            begin
                unique case (st_q)
                    ST_ADDR:
                        if (cnt_q == 4'h8)
                        begin
                            if (shift_q[7:1] == TARGET_ADDR)
                            begin
                                rw_q   <= shift_q[0];
                                sda_oe <= 1'b1;
                                st_q   <= ST_AACK;
                            end
                            else
                                st_q <= ST_IDLE;
                        end
                    ST_AACK:
                        if (rw_q)
                        begin
                            shift_q <= rd_c;
                            sda_oe  <= !rd_c[7];
                            cnt_q   <= 4'h1;
                            st_q    <= ST_RD;
                        end
                        else
                        begin
                            sda_oe <= 1'b0;
                            cnt_q  <= 4'h0;
                            st_q   <= ST_PTR;
                        end
                    ST_PTR:
                        if (cnt_q == 4'h8)
                        begin
                            ptr_q  <= shift_q;
                            sda_oe <= 1'b1;
                            st_q   <= ST_PACK;
                        end
                    ST_WR:
                        if (cnt_q == 4'h8)
                        begin
                            wr_stb_q <= 1'b1;
                            sda_oe   <= 1'b1;
                            st_q     <= ST_WACK;
                        end
                    ST_PACK, ST_WACK:
                    begin
                        sda_oe <= 1'b0;
                        cnt_q  <= 4'h0;
                        st_q   <= ST_WR;
                    end
                    ST_RD:
                        if (cnt_q == 4'h8)
                        begin
                            sda_oe <= 1'b0;
                            st_q   <= ST_RACK;
                        end
                        else
                        begin
                            sda_oe  <= !shift_q[6];
                            shift_q <= {shift_q[6:0], 1'b0};
                            cnt_q   <= cnt_q + 4'h1;
                        end
                    ST_RACK:
                        if (ack_q)
                        begin
                            shift_q <= rd_c;
                            sda_oe  <= !rd_c[7];
                            cnt_q   <= 4'h1;
                            st_q    <= ST_RD;
                        end
                        else
                            st_q <= ST_IDLE;
                    default:
                        st_q <= ST_IDLE;
                endcase
                if (st_q == ST_WR && cnt_q == 4'h8)
                begin
                    wr_data_q <= shift_q;
                    wr_ptr_q  <= ptr_q;
                    ptr_q     <= ptr_q + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            setup_q  <= REG_RESET;
            en29_q   <= REG_RESET;
            shared_q <= REG_RESET;
            conv_q   <= REG_RESET;
            for (int i = 0; i < NUM_CH; i++)
                code_q[i] <= REG_RESET;
        end
        else if (wr_stb_q)
        begin
            case (wr_ptr_q)
                OFS_CH_SETUP:    setup_q  <= wr_data_q;
                OFS_CH_EN_2_9:   en29_q   <= wr_data_q;
                OFS_SHARED_CODE: shared_q <= wr_data_q;
                OFS_CONV_SETUP:  conv_q   <= wr_data_q;
                default:
                    if (wr_ptr_q >= OFS_CH1_CODE && wr_ptr_q <= OFS_CH9_CODE)
                        code_q[4'(wr_ptr_q - OFS_CH1_CODE)] <= wr_data_q;
            endcase
        end
    end

    // clear by write-only bit or pin rising
    assign clr_d = (wr_stb_q && wr_ptr_q == OFS_ERR_CLEAR && wr_data_q[CLEAR_BIT])
                   || (err_clear_pin && !clr_pin_q);

    assign excl_c = (setup_q[SETUP_EXCL_LSB+:4] > 4'(NUM_CH - 1)) ? 4'(NUM_CH - 1)
                                                                   : setup_q[SETUP_EXCL_LSB+:4];
    // channel requests from selected scheme
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (setup_q[SETUP_GLOBAL_BIT])
                req_c[i] = setup_q[SETUP_GLOBAL_ON]
                           && (i + int'(excl_c) < NUM_CH);
            else if (i == 0)
                req_c[i] = setup_q[SETUP_CH1_ON];
            else
                req_c[i] = en29_q[i-1];
        end
    end

    assign cond_c = open_detect | short_detect;

    // per-channel fault latches
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            fault_q                     <= '0;
            {open_flag_q, short_flag_q} <= 2'h0;
        end
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
                // latch on a driven channel; set wins over clear
                fault_q[i] <= (cond_c[i] && chan_on[i])
                              || (fault_q[i] && !(clr_d && !cond_c[i]));
            open_flag_q  <= |(open_detect & chan_on)
                            || (open_flag_q && !(clr_d && !(|open_detect)));
            short_flag_q <= |(short_detect & chan_on)
                            || (short_flag_q && !(clr_d && !(|short_detect)));
        end
    end

    // converter, sink and alarm outputs
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            {active, conv_enable, conv_auto_skip, alarm_out, alarm_oe} <= 5'h00;
            chan_on                                                    <= '0;
            chan_code                                                  <= '0;
        end
        else
        begin
            // enable gates active, the converter enable and the channel drives
            active         <= hw_enable;
            conv_enable    <= hw_enable && conv_q[CONV_ON_A_BIT] && conv_q[CONV_ON_B_BIT];
            conv_auto_skip <= conv_q[CONV_SW_SEL_BIT] ? conv_q[CONV_SKIP_BIT] : mode_pin;
            chan_on        <= {NUM_CH{hw_enable}} & req_c & ~fault_q;
            for (int i = 0; i < NUM_CH; i++)
                chan_code[i] <= setup_q[SETUP_GLOBAL_BIT] ? shared_q[CODE_W-1:0]
                                                          : code_q[i][CODE_W-1:0];
            alarm_out      <= 1'b0;
            // alarm held until every per-channel fault latch clears
            alarm_oe       <= |fault_q;
        end
    end

endmodule // ils_top

// [verif/ils_top_properties.sv]
`timescale 1ns/10ps
module ils_top_properties
    import ils_pkg::*;
#(
    parameter int NUM_CH = 9
)(
    // clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // serial port
    input wire logic              scl_in,
    input wire logic              sda_out,
    input wire logic              sda_oe,
    // pins and sense
    input wire logic              hw_enable,
    input wire logic              err_clear_pin,
    input wire logic [NUM_CH-1:0] open_detect,
    input wire logic [NUM_CH-1:0] short_detect,
    // outputs
    input wire logic              active,
    input wire logic              conv_enable,
    input wire logic [NUM_CH-1:0] chan_on,
    input wire logic              alarm_out,
    input wire logic              alarm_oe
);
    logic [2:0] up_q;
    wire        ready    = up_q == 3'h5;
    wire        cond_any = |(open_detect | short_detect);
    wire        hit      = |((open_detect | short_detect) & chan_on);

    // count edges until the synchronised reset has surely let go
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            up_q <= 3'h0;
        else if (!ready)
            up_q <= up_q + 3'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !ready);

    sequence s_hit(logic c, logic o);
        c && o;
    endsequence
    sequence s_shut(logic o);
        ##2 (!o && alarm_oe);
    endsequence

    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_ch
        a_open_shuts_chan:
        assert property (s_hit(open_detect[i], chan_on[i]) |-> s_shut(chan_on[i]))
            else $error("open channel still driven");
        a_short_shuts_chan:
        assert property (s_hit(short_detect[i], chan_on[i]) |-> s_shut(chan_on[i]))
            else $error("shorted channel still driven");
        a_faulted_stays_off:
        assert property (alarm_oe && !chan_on[i] && (open_detect[i] || short_detect[i])
            |=> !chan_on[i]) else $error("faulted channel came back");
    end

    a_active_tracks_en:
    assert property (active == $past(hw_enable)) else $error("active not following enable");
    a_conv_needs_en:
    assert property (!hw_enable |=> !conv_enable) else $error("converter on in shutdown");
    a_drains_only_low:
    assert property (!sda_out && !alarm_out) else $error("open-drain output driven high");
    a_alarm_has_cause:
    assert property ($rose(alarm_oe) |-> $past(hit, 2)) else $error("alarm without fault");
    a_alarm_release_clean:
    assert property ($fell(alarm_oe) |-> !$past(cond_any)) else $error("alarm dropped early");
    a_pin_clear_releases:
    assert property (alarm_oe && !cond_any && $rose(err_clear_pin) |-> ##[1:3] !alarm_oe)
        else $error("clear pin did not release alarm");
    a_hold_while_present:
    assert property (alarm_oe && cond_any |=> alarm_oe) else $error("alarm cleared too soon");
    a_sda_moves_low:
    assert property ($changed(sda_oe) |-> !scl_in) else $error("data changed with clock high");
endmodule // ils_top_properties

bind ils_top ils_top_properties #(.NUM_CH(NUM_CH)) u_props (
    .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .hw_enable(hw_enable), .err_clear_pin(err_clear_pin), .open_detect(open_detect),
    .short_detect(short_detect), .active(active), .conv_enable(conv_enable),
    .chan_on(chan_on), .alarm_out(alarm_out), .alarm_oe(alarm_oe)
);

// [verif/ils_host_model.sv]
`timescale 1ns/10ps
module ils_host_model
    import ils_pkg::*;
(
    // clock
    input  wire logic clk,
    // bus lines
    output logic      scl,
    output logic      sda,
    input  wire logic sda_oe
);
    logic host_low = 1'b0;

    // pull-up: wire is low when either party pulls
    assign sda = !(host_low || sda_oe);
    initial scl = 1'b1;

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // data moves only while the clock is low
    task automatic put_bit(input logic b, output logic seen);
        tick(1);
        host_low = !b;
        tick(3);
        scl = 1'b1;
        tick(4);
        seen = sda;
        scl = 1'b0;
    endtask
    task automatic start;
        tick(1);
        host_low = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        host_low = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic stop;
        tick(1);
        host_low = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(4);
        host_low = 1'b0;
        tick(4);
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            put_bit(b[i], s);
        put_bit(1'b1, s);
        ack = !s;
    endtask
    task automatic probe(input logic [7:0] adr, output logic ok);
        start;
        send(adr, ok);
        stop;
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] q [$], output logic ok);
        logic a;
        start;
        send({TARGET_ADDR, 1'b0}, ok);
        send(ofs, a);
        ok &= a;
        foreach (q[k])
        begin
            send(q[k], a);
            ok &= a;
        end
        stop;
    endtask
    task automatic rd(input logic [7:0] ofs, input int n, output logic [7:0] q [$]);
        logic       a;
        logic [7:0] b;
        q = {};
        start;
        send({TARGET_ADDR, 1'b0}, a);
        send(ofs, a);
        start;
        send({TARGET_ADDR, 1'b1}, a);
        for (int k = 0; k < n; k++)
        begin
            for (int i = 7; i >= 0; i--)
                put_bit(1'b1, b[i]);
            put_bit(k == n - 1, a);
            q.push_back(b);
        end
        stop;
    endtask
endmodule // ils_host_model

// [verif/ils_top_tb.sv]
`timescale 1ns/10ps
module ils_top_tb
    import ils_pkg::*;
;
    logic            clk = 1'b0;
    logic            rst_n, scl, sda, sda_out, sda_oe, active, conv_enable, conv_auto_skip;
    logic            hw_enable, mode_pin, err_clear_pin, alarm_out, alarm_oe;
    logic            supply_fault, thermal_fault, vout_ovp_fault;
    logic [8:0]      open_detect, short_detect, chan_on;
    logic [8:0][5:0] chan_code;
    logic [31:0]     seed = 32'hED0A;
    logic [7:0]      q [$];
    logic            ok;
    int              failures, comparisons, open_m, short_m, k;
    int              mdl [0:19];

    always #4 clk = ~clk;

    ils_top dut (
        .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .hw_enable(hw_enable), .mode_pin(mode_pin),
        .err_clear_pin(err_clear_pin), .open_detect(open_detect), .short_detect(short_detect),
        .supply_fault(supply_fault), .thermal_fault(thermal_fault),
        .vout_ovp_fault(vout_ovp_fault), .active(active), .conv_enable(conv_enable),
        .conv_auto_skip(conv_auto_skip), .chan_on(chan_on), .chan_code(chan_code),
        .alarm_out(alarm_out), .alarm_oe(alarm_oe)
    );
    ils_host_model host (.clk(clk), .scl(scl), .sda(sda), .sda_oe(sda_oe));

    function automatic logic [31:0] next_rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        comparisons++;
        if (seen !== expd)
        begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic tally_and_finish;
        if (failures == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic settle;
        repeat (6) @(negedge clk);
    endtask
    task automatic mdl_clear;
        open_m &= int'(open_detect);
        short_m &= int'(short_detect);
    endtask
    task automatic mdl_wr(input int a, input int d);
        if ((a >= 2 && a <= 13) || a == 17)
            mdl[a] = d;
        if (a == 16 && d % 2 == 1)
            mdl_clear;
    endtask
    function automatic int exp_on(input int i);
        int s = mdl[2];
        if (!hw_enable || ((open_m | short_m) >> i) % 2)
            return 0;
        if ((s >> 7) % 2)
            return (i + (((s >> 2) & 15) > 8 ? 8 : (s >> 2) & 15) < 9) && ((s >> 1) % 2);
        return i == 0 ? s % 2 : (mdl[3] >> (i - 1)) % 2;
    endfunction
    function automatic int exp_rd(input int a);
        int lat = open_m | short_m;
        case (a)
            14: return (open_m != 0) * 128 + (short_m != 0) * 64 + (lat & 63);
            15: return int'(supply_fault) * 128 + (lat >> 6);
            19: return int'(vout_ovp_fault) * 4 + int'(thermal_fault) * 2 + int'(hw_enable);
            16, 18: return 0;
            default: return mdl[a];
        endcase
    endfunction
    task automatic bus_wr(input logic [7:0] ofs, input logic [7:0] d [$]);
        host.wr(ofs, d, ok);
        check(ok, 1);
        foreach (d[j]) mdl_wr(ofs + j, d[j]);
    endtask
    task automatic bus_rd(input logic [7:0] ofs, input int n);
        logic [7:0] r [$];
        host.rd(ofs, n, r);
        check(r.size(), n);
        foreach (r[j]) check(r[j], exp_rd(ofs + j));
    endtask
    task automatic check_outs;
        int c = mdl[17];
        for (int i = 0; i < 9; i++)
        begin
            check(chan_on[i], exp_on(i));
            if (exp_on(i)) check(chan_code[i], (mdl[2] >> 7) % 2 ? mdl[4] & 63 : mdl[5 + i] & 63);
        end
        check(conv_enable, int'(hw_enable) & (c >> 3) & (c >> 2) & 1);
        check(conv_auto_skip, (c >> 1) % 2 ? c % 2 : int'(mode_pin));
        check(alarm_oe, (open_m | short_m) != 0);
        check(active, hw_enable);
        check(alarm_out, 0);
        check(sda_out, 0);
    endtask
    task automatic do_clear(input int kind);
        if (kind == 0)
            bus_wr(8'h10, '{8'h01});
        else
        begin
            err_clear_pin = 1'b1;
            settle;
            err_clear_pin = 1'b0;
            mdl_clear;
        end
        settle;
    endtask

    initial
    begin
        rst_n = 1'b0;
        {hw_enable, mode_pin, err_clear_pin, supply_fault, thermal_fault, vout_ovp_fault} = 6'h0;
        {open_detect, short_detect} = 18'h0;
        foreach (mdl[j]) mdl[j] = 0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        host.probe(8'h42, ok);
        check(ok, 0);
        for (int it = 0; it < 6; it++)
        begin
            hw_enable = 1'b0;
            settle;
            bus_rd(8'h02, 18);
            q = {};
            for (int a = 2; a < 20; a++) q.push_back(8'(next_rnd()));
            q[0][7] = it[0];
            q[0][1] = it != 5;
            if (it == 1) q[0][5:2] = 4'hF;
            if (it == 3) q[0][5:2] = 4'h0;
            {mode_pin, supply_fault, thermal_fault, vout_ovp_fault} = 4'(next_rnd());
            bus_wr(8'h02, q);
            settle;
            check_outs;
            hw_enable = 1'b1;
            settle;
            check_outs;
            bus_rd(8'h11, 3);
        end
        bus_wr(8'h02, '{8'h01, 8'hFF});
        for (int kind = 0; kind < 2; kind++)
        begin
            k = int'(next_rnd() % 9);
            if (kind == 0) open_detect[k] = 1'b1;
            else short_detect[k] = 1'b1;
            if (kind == 0) open_m = 1 << k;
            else short_m = 1 << k;
            settle;
            check_outs;
            bus_rd(8'h0E, 2);
            do_clear(kind);
            check_outs;
            {open_detect, short_detect} = 18'h0;
            settle;
            check_outs;
            do_clear(kind);
            check_outs;
            bus_rd(8'h0E, 2);
        end
        tally_and_finish;
    end

    initial
    begin
        repeat (90000) @(posedge clk);
        failures++;
        tally_and_finish;
    end
endmodule // ils_top_tb
